/* rtl/latch_loader_pkg.sv */
// Purpose: Shared constants for the three-wire latch loader link
// Assumes: 24-bit words, msb first, two select bits at the bottom
// Notes:   Timing counts derive from the core clock rate
package latch_loader_pkg;
  localparam int unsigned WORD_BITS      = 24;
  localparam int unsigned BYTE_BITS      = 8;
  localparam int unsigned BYTES_PER_WORD = 3;
  localparam int unsigned SEL_LSB        = 0;
  localparam int unsigned SEL_BITS       = 2;
  localparam logic [1:0]  SEL_REF        = 2'h0;
  localparam logic [1:0]  SEL_FEEDBACK   = 2'h1;
  localparam logic [1:0]  SEL_FUNCTION   = 2'h2;
  localparam logic [1:0]  SEL_INIT       = 2'h3;
  // Monitor select field inside function and init words
  localparam int unsigned MON_LSB        = 4;
  localparam int unsigned MON_BITS       = 3;
  localparam logic [2:0]  MON_LOW        = 3'h0;
  localparam logic [2:0]  MON_LOCK       = 3'h1;
  localparam logic [2:0]  MON_HIGH       = 3'h7;
  localparam logic [23:0] LATCH_RESET    = 24'h000000;
  localparam int unsigned CORE_CLK_HZ    = 10_000_000;
  localparam int unsigned SCLK_MAX_HZ    = 20_000_000;
  // Host divider: half period in core cycles, at least one
  localparam int unsigned SCLK_HALF_CYC  =
    (CORE_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ) < 1 ? 1 :
    (CORE_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
endpackage : latch_loader_pkg

/* rtl/latch_link_if.sv */
// Purpose: Three-wire serial link between host and synthesizer port
// Assumes: Host drives clock, data, strobe and enable; the device only answers on monitor
// Notes:   No clocking block; the bench joins host and device instances by assigns
`timescale 1ns/1ps
interface latch_link_if;
  logic serial_clk;
  logic serial_data_in;
  logic latch_load_strobe;
  logic chip_enable;
  logic monitor_output_pin;

  modport host_end (
    output serial_clk,
    output serial_data_in,
    output latch_load_strobe,
    output chip_enable,
    input  monitor_output_pin
  );
  modport device_end (
    input  serial_clk,
    input  serial_data_in,
    input  latch_load_strobe,
    input  chip_enable,
    output monitor_output_pin
  );
endinterface : latch_link_if

/* rtl/latch_loader_device.sv */
// Purpose: Device end: shift register and three latches for four select codes
// Assumes: Runs on the host serial clock; strobe and enable are pins
// Notes:   Latches hold until rewritten or reset; power-down keeps the port alive
`timescale 1ns/1ps
// Operation
// - Sample data on every rising serial clock
// - Strobe rise moves 24 bits to latch
// - Host serial clock at most 20 MHz
// - Strobe low, three bytes, strobe high
// - Host writes reference, feedback, init first
// - Monitor pin shows selected signal, lock too
// - Chip enable low powers device down
// - Two lsbs select destination latch
// - Shifting works while powered down
module latch_loader_device (
  input  wire logic  reset_n_i,
  input  wire logic  lock_indication_i,
  latch_link_if.device_end link,
  output logic [23:0] ref_latch_o,
  output logic [23:0] feedback_latch_o,
  output logic [23:0] function_latch_o,
  output logic        init_pulse_o,
  output logic        powered_down_o,
  output logic        active_o
);
  // Bits that enter while the strobe is synchronised
  localparam int unsigned LAG       = 3;
  localparam int unsigned SHIFT_LEN = latch_loader_pkg::WORD_BITS + LAG;

  typedef struct packed {
    logic [SHIFT_LEN-1:0] shift;
    logic [2:0]  le_sync;
    logic [2:0]  ce_sync;
    logic [2:0]  lock_sync;
    logic        le_seen;
    logic [23:0] ref_l;
    logic [23:0] fb_l;
    logic [23:0] fn_l;
    logic        init_p;
    logic [2:0]  written;
    logic        pd;
    logic        mon;
    logic        active;
  } state_t;

  // Idle strobe is high; sync starts high so reset loads nothing
  localparam state_t S_RESET = '{
    shift:     '0,
    le_sync:   3'h7,
    ce_sync:   3'h7,
    lock_sync: 3'h0,
    le_seen:   1'b1,
    ref_l:     latch_loader_pkg::LATCH_RESET,
    fb_l:      latch_loader_pkg::LATCH_RESET,
    fn_l:      latch_loader_pkg::LATCH_RESET,
    init_p:    1'b0,
    written:   3'h0,
    pd:        1'b0,
    mon:       1'b0,
    active:    1'b0
  };

  state_t      s_q;
  state_t      s_d;
  logic [23:0] word_in;
  logic [3:0]  dest;

  // Word layout must suit the fixed 24-bit latches
  if (latch_loader_pkg::WORD_BITS != 24)
  begin : g_bad_word
    $error("word width must be 24");
  end
  if (latch_loader_pkg::BYTE_BITS * latch_loader_pkg::BYTES_PER_WORD != latch_loader_pkg::WORD_BITS)
  begin : g_bad_bytes
    $error("bytes do not fill one word");
  end
  if (latch_loader_pkg::SEL_BITS != 2)
  begin : g_bad_sel_width
    $error("select field must be two bits");
  end
  if (latch_loader_pkg::SEL_LSB + latch_loader_pkg::SEL_BITS > latch_loader_pkg::WORD_BITS)
  begin : g_bad_sel
    $error("select field outside word");
  end
  if (latch_loader_pkg::MON_BITS != 3)
  begin : g_bad_mon_width
    $error("monitor field must be three bits");
  end
  if (latch_loader_pkg::MON_LSB + latch_loader_pkg::MON_BITS > latch_loader_pkg::WORD_BITS)
  begin : g_bad_mon
    $error("monitor field outside word");
  end

  // A synchronised level counts once its last two stages agree
  function automatic logic settled(input logic [2:0] sync);
    settled = (sync[2] == sync[1]);
  endfunction : settled

  // One-hot destination latch from the select bits
  function automatic logic [3:0] dest_of(input logic [23:0] word);
    dest_of = 4'h0;
    unique case (word[latch_loader_pkg::SEL_LSB +: latch_loader_pkg::SEL_BITS])
      latch_loader_pkg::SEL_REF:
      begin
        dest_of = 4'h1;
      end
      latch_loader_pkg::SEL_FEEDBACK:
      begin
        dest_of = 4'h2;
      end
      latch_loader_pkg::SEL_FUNCTION:
      begin
        dest_of = 4'h4;
      end
      latch_loader_pkg::SEL_INIT:
      begin
        dest_of = 4'h8;
      end
    endcase
  endfunction : dest_of

  // The word sits above the bits shifted in during synchronisation
  assign word_in = s_q.shift[LAG +: latch_loader_pkg::WORD_BITS];
  assign dest    = dest_of(word_in);

  always_comb
  begin
    s_d = s_q;
    s_d.init_p = 1'b0;
    // Every rising edge shifts, inside a frame or not
    s_d.shift = {s_q.shift[SHIFT_LEN-2:0], link.serial_data_in};
    s_d.le_sync = {s_q.le_sync[1:0], link.latch_load_strobe};
    s_d.ce_sync = {s_q.ce_sync[1:0], link.chip_enable};
    s_d.lock_sync = {s_q.lock_sync[1:0], lock_indication_i};

    if (settled(s_q.le_sync))
    begin
      s_d.le_seen = s_q.le_sync[1];
    end
    if (settled(s_q.ce_sync))
    begin
      s_d.pd = ~s_q.ce_sync[1];
    end

    // Settled rising strobe moves the word into its latch
    if (settled(s_q.le_sync) && s_q.le_sync[1] && !s_q.le_seen)
    begin
      if (dest[0])
      begin
        s_d.ref_l = word_in;
        s_d.written[0] = 1'b1;
      end
      if (dest[1])
      begin
        s_d.fb_l = word_in;
        s_d.written[1] = 1'b1;
      end
      // Init loads the function latch as well
      if (dest[2] || dest[3])
      begin
        s_d.fn_l = word_in;
      end
      if (dest[3])
      begin
        s_d.init_p = 1'b1;
        s_d.written[2] = 1'b1;
      end
    end

    case (s_q.fn_l[latch_loader_pkg::MON_LSB +: latch_loader_pkg::MON_BITS])
      latch_loader_pkg::MON_LOCK:
      begin
        if (settled(s_q.lock_sync))
        begin
          s_d.mon = s_q.lock_sync[1];
        end
      end
      latch_loader_pkg::MON_HIGH:
      begin
        s_d.mon = 1'b1;
      end
      default:
      begin
        s_d.mon = 1'b0;
      end
    endcase

    // Output starts only after reference, feedback and init loads
    s_d.active = &s_d.written & ~s_d.pd;
  end

  always_ff @(posedge link.serial_clk or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_q <= S_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign link.monitor_output_pin = s_q.mon;
  assign ref_latch_o      = s_q.ref_l;
  assign feedback_latch_o = s_q.fb_l;
  assign function_latch_o = s_q.fn_l;
  assign init_pulse_o     = s_q.init_p;
  assign powered_down_o   = s_q.pd;
  assign active_o         = s_q.active;
endmodule : latch_loader_device

/* rtl/latch_loader_host.sv */
// Purpose: Host end: loads one 24-bit word per request as three bytes
// Assumes: Serial clock made by dividing core_clk_i, idle low
// Notes:   Strobe low through the word; data changes on falling edge
`timescale 1ns/1ps
module latch_loader_host #(
  parameter int unsigned HALF_CYC = latch_loader_pkg::SCLK_HALF_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        req_valid_i,
  input  wire logic [23:0] req_word_i,
  input  wire logic        chip_enable_i,
  output logic             req_ready_o,
  output logic             done_o,
  output logic             lock_o,
  latch_link_if.host_end   link
);
  // Divider counter is eight bits wide
  if (HALF_CYC < 1 || HALF_CYC > 255)
  begin : g_bad_half
    $error("HALF_CYC out of range");
  end

  typedef enum logic [1:0] {IDLE, SHIFT, STROBE} phase_t;
  typedef struct packed {
    phase_t      phase;
    logic [23:0] word;
    logic [4:0]  bits;
    logic [7:0]  div;
    logic        sclk;
    logic        le;
    logic        ce;
    logic        ready;
    logic        done;
    logic [2:0]  mon_sync;
    logic        lock;
  } state_t;

  state_t s_q;
  state_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.ce = chip_enable_i;
    s_d.mon_sync = {s_q.mon_sync[1:0], link.monitor_output_pin};
    if (s_q.mon_sync[2] == s_q.mon_sync[1])
    begin
      s_d.lock = s_q.mon_sync[1];
    end
    unique case (s_q.phase)
      IDLE:
      begin
        if (req_valid_i && s_q.ready)
        begin
          s_d.word  = req_word_i;
          s_d.bits  = 5'(latch_loader_pkg::WORD_BITS);
          s_d.le    = 1'b0;
          s_d.div   = '0;
          s_d.ready = 1'b0;
          s_d.phase = SHIFT;
        end
      end
      SHIFT:
      begin
        if (s_q.div == 8'(HALF_CYC - 1))
        begin
          s_d.div  = '0;
          s_d.sclk = ~s_q.sclk;
          if (s_q.sclk)
          begin
            s_d.word = {s_q.word[22:0], 1'b0};
            s_d.bits = s_q.bits - 5'h1;
            if (s_q.bits == 5'h1)
            begin
              s_d.phase = STROBE;
            end
          end
        end
        else
        begin
          s_d.div = s_q.div + 8'h1;
        end
      end
      STROBE:
      begin
        s_d.le    = 1'b1;
        s_d.done  = 1'b1;
        s_d.ready = 1'b1;
        s_d.phase = IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_q <= '{phase: IDLE, word: '0, bits: '0, div: '0, sclk: 1'b0, le: 1'b1,
               ce: 1'b0, ready: 1'b1, done: 1'b0, mon_sync: '0, lock: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign link.serial_clk        = s_q.sclk;
  assign link.serial_data_in    = s_q.word[23];
  assign link.latch_load_strobe = s_q.le;
  assign link.chip_enable       = s_q.ce;
  assign req_ready_o = s_q.ready;
  assign done_o      = s_q.done;
  assign lock_o      = s_q.lock;
endmodule : latch_loader_host

/* sim/latch_loader_properties.sv */
// Purpose: Checks on the host-made link wires
// Assumes: Host half period of one core cycle
// Notes:   Strobe frames one word
`timescale 1ns/1ps
module latch_loader_properties (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic latch_load_strobe
);
  logic [4:0] rises_q;
  logic       sclk_q;
  // Rising serial edges seen inside one frame
  always_ff @(posedge core_clk_i or negedge reset_n_i)
    if (!reset_n_i)
      {rises_q, sclk_q} <= 6'h00;
    else
    begin
      sclk_q  <= serial_clk;
      rises_q <= latch_load_strobe ? 5'h00 : rises_q + 5'(serial_clk & ~sclk_q);
    end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_open; $fell(latch_load_strobe); endsequence
  sequence s_close; $rose(latch_load_strobe); endsequence
  property p_bits; s_close |-> rises_q == 5'h18; endproperty
  a_bits: assert property (p_bits) else $error("bad bit count");
  property p_low; s_open |-> ##1 (!latch_load_strobe)[*8]; endproperty
  a_low: assert property (p_low) else $error("strobe bounced");
  property p_len; s_open |-> ##[40:60] s_close; endproperty
  a_len: assert property (p_len) else $error("frame too long");
  property p_idle; latch_load_strobe && $past(latch_load_strobe) |-> !serial_clk; endproperty
  a_idle: assert property (p_idle) else $error("clock outside frame");
  property p_setup; $rose(serial_clk) |-> $stable(serial_data_in); endproperty
  a_setup: assert property (p_setup) else $error("data moved at rise");
  property p_rate; $rose(serial_clk) |=> $fell(serial_clk); endproperty
  a_rate: assert property (p_rate) else $error("clock high too long");
  property p_end; s_close |-> !serial_clk && $past(serial_clk, 2); endproperty
  a_end: assert property (p_end) else $error("strobe rose mid bit");
  property p_hold; s_close |-> latch_load_strobe[*2]; endproperty
  a_hold: assert property (p_hold) else $error("strobe dropped early");
endmodule : latch_loader_properties

/* sim/three_wire_latch_loader_test.sv */
// Purpose: Both ends joined; loads checked end to end
// Assumes: Half period one core cycle
// Notes:   Device clock runs free while strobe is high
`timescale 1ns/1ps
module three_wire_latch_loader_test;
  typedef struct packed {logic [23:0] w, r, f, n; logic a, l;} row_t;
  row_t        rows [4];
  logic        core_clk_i = 0, link_clk = 0, free_en = 0, reset_n_i = 0, vld = 0, ce = 1, lck = 1;
  logic [23:0] word = 0, cap = 0, ref_o, fb_o, fn_o;
  logic        rdy, done, lock, init, pd, act;
  int          n_mismatch, samples_checked, cyc, n_init;
  latch_link_if link ();
  latch_link_if dlink ();
  // Free clock lets the device finish its strobe sync
  assign dlink.serial_clk = free_en & link.latch_load_strobe ? link_clk : link.serial_clk;
  assign dlink.serial_data_in = link.serial_data_in;
  assign dlink.latch_load_strobe = link.latch_load_strobe;
  assign dlink.chip_enable = link.chip_enable;
  assign link.monitor_output_pin = dlink.monitor_output_pin;
  latch_loader_host #(.HALF_CYC(1)) latch_loader_host_i (.core_clk_i, .reset_n_i, .req_valid_i(vld),
    .req_word_i(word), .chip_enable_i(ce), .req_ready_o(rdy), .done_o(done), .lock_o(lock), .link(link.host_end));
  latch_loader_device latch_loader_device_i (.reset_n_i, .lock_indication_i(lck), .link(dlink.device_end),
    .ref_latch_o(ref_o), .feedback_latch_o(fb_o), .function_latch_o(fn_o), .init_pulse_o(init),
    .powered_down_o(pd), .active_o(act));
  latch_loader_properties latch_loader_properties_i (.core_clk_i, .reset_n_i, .serial_clk(link.serial_clk),
    .serial_data_in(link.serial_data_in), .latch_load_strobe(link.latch_load_strobe));
  initial forever #50 core_clk_i = ~core_clk_i;
  initial #37 forever #80 link_clk = ~link_clk;
  always @(negedge link_clk) free_en <= link.latch_load_strobe;
  always @(posedge link.serial_clk) if (!link.latch_load_strobe) cap = {cap[22:0], link.serial_data_in};
  always @(posedge init) n_init++;
  always @(posedge core_clk_i) if (++cyc == 20000) begin n_mismatch++; tally_and_finish(); end
  task automatic chk24(input string s, input logic [23:0] e, g);
    samples_checked++;
    if (g !== e) begin n_mismatch++; $display("Error %s expected %h seen %h", s, e, g); end
  endtask : chk24
  task automatic chk1(input string s, input logic e, g);
    samples_checked++;
    if (g !== e) begin n_mismatch++; $display("Error %s expected %b seen %b", s, e, g); end
  endtask : chk1
  task automatic load(input logic [23:0] w);
    chk1("ready", 1'b1, rdy);
    word = w;
    vld = 1;
    @(posedge core_clk_i) #1 vld = 0;
    for (int i = 0; i < 99 && done !== 1'b1; i++) @(posedge core_clk_i) #1;
    chk1("done", 1'b1, done);
    chk24("wire word", w, cap);
    repeat (20) @(posedge core_clk_i);
    #1;
  endtask : load
  task automatic tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    rows[0] = {24'ha5c3f0, 24'ha5c3f0, 24'h0, 24'h0, 2'h0};
    rows[1] = {24'h3c5a11, 24'ha5c3f0, 24'h3c5a11, 24'h0, 2'h0};
    rows[2] = {24'h0f0f12, 24'ha5c3f0, 24'h3c5a11, 24'h0f0f12, 2'h1};
    rows[3] = {24'h81e073, 24'ha5c3f0, 24'h3c5a11, 24'h81e073, 2'h3};
    repeat (10) @(posedge core_clk_i);
    #1 reset_n_i = 1;
    repeat (20) @(posedge core_clk_i);
    #1;
    foreach (rows[k])
    begin
      load(rows[k].w);
      chk24("ref", rows[k].r, ref_o);
      chk24("feedback", rows[k].f, fb_o);
      chk24("function", rows[k].n, fn_o);
      chk1("active", rows[k].a, act);
      chk1("lock", rows[k].l, lock);
    end
    chk1("init pulse", 1'b1, n_init == 1);
    lck = 0;
    load(24'h0f0f12);
    chk1("lock", 1'b0, lock);
    ce = 0;
    load(24'h123450);
    chk1("powered down", 1'b1, pd);
    chk1("active", 1'b0, act);
    chk24("ref", 24'h123450, ref_o);
    ce = 1;
    load(24'h3c5a11);
    chk1("active", 1'b1, act);
    reset_n_i = 0;
    repeat (10) @(posedge core_clk_i);
    #1 reset_n_i = 1;
    chk24("ref", 24'h0, ref_o);
    chk1("active", 1'b0, act);
    repeat (20) @(posedge core_clk_i);
    #1;
    chk24("ref after reset", 24'h0, ref_o);
    chk1("init after reset", 1'b1, n_init == 1);
    tally_and_finish();
  end
endmodule : three_wire_latch_loader_test
